// ===== shared/blexec_pkg.sv
// package: opcodes, field layout, timing and carrier types for the exec block
package blexec_pkg;
    // ************************************************************
    // instruction word layout
    // ************************************************************
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int FADDR_W = 7;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int DEST_BIT = 7;
    localparam int BRANCH_TOP_W = 3;
    localparam int PCL_LO = 3;
    localparam int PCL_HI = 4;
    localparam int NIB_W = 4;
    // ************************************************************
    // opcode encodings
    // ************************************************************
    localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
    localparam logic [5:0] OP_INC_SKIP = 6'h0F;
    localparam logic [5:0] OP_INC_FILE = 6'h0A;
    localparam logic [5:0] OP_OR_FILE = 6'h04;
    localparam logic [5:0] OP_XOR_FILE = 6'h06;
    localparam logic [5:0] OP_SWAP = 6'h0E;
    localparam logic [5:0] OP_OR_LIT = 6'h38;
    localparam logic [5:0] OP_XOR_LIT = 6'h3A;
    localparam logic [2:0] OP_BRANCH = 3'h5;
    localparam logic [13:0] NOP_WORD = 14'h0000;
    // ************************************************************
    // timing: four clocks per instruction cycle
    // ************************************************************
    localparam int PHASES = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [7:0] ONE8 = 8'h01;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;

    typedef enum logic [3:0] {
        BLEX_NONE = 4'h0,
        BLEX_DEC_SKIP = 4'h1,
        BLEX_INC_SKIP = 4'h2,
        BLEX_INC_FILE = 4'h3,
        BLEX_OR_FILE = 4'h4,
        BLEX_XOR_FILE = 4'h5,
        BLEX_SWAP = 4'h6,
        BLEX_OR_LIT = 4'h7,
        BLEX_XOR_LIT = 4'h8,
        BLEX_BRANCH = 4'h9
    } blex_op_t;

    typedef enum logic [1:0] {
        BLEX_ST_EXEC = 2'h0,
        BLEX_ST_FLUSH = 2'h1
    } blex_state_t;

    // file register write request
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } blex_fwr_t;
endpackage

// ===== rtl/blexec_decode.sv
// decoder: turns a 14-bit instruction word into an operation code
`timescale 1ns/1ps
module blexec_decode (
    // instruction in
    input wire logic [13:0] instr,
    // decoded operation
    output blexec_pkg::blex_op_t op
);
    // ************************************************************
    // opcode match
    // ************************************************************
    // literal ops ignore bit 8, so compare only the top five bits
    always_comb begin
        op = blexec_pkg::BLEX_NONE;
        if (instr[13:11] == blexec_pkg::OP_BRANCH) begin
            op = blexec_pkg::BLEX_BRANCH;
        end else if (instr[13:9] == blexec_pkg::OP_OR_LIT[5:1]) begin
            op = blexec_pkg::BLEX_OR_LIT;
        end else if (instr[13:9] == blexec_pkg::OP_XOR_LIT[5:1]) begin
            op = blexec_pkg::BLEX_XOR_LIT;
        end else begin
            case (instr[13:8])
                blexec_pkg::OP_DEC_SKIP: op = blexec_pkg::BLEX_DEC_SKIP;
                blexec_pkg::OP_INC_SKIP: op = blexec_pkg::BLEX_INC_SKIP;
                blexec_pkg::OP_INC_FILE: op = blexec_pkg::BLEX_INC_FILE;
                blexec_pkg::OP_OR_FILE: op = blexec_pkg::BLEX_OR_FILE;
                blexec_pkg::OP_XOR_FILE: op = blexec_pkg::BLEX_XOR_FILE;
                blexec_pkg::OP_SWAP: op = blexec_pkg::BLEX_SWAP;
                default: op = blexec_pkg::BLEX_NONE;
            endcase
        end
    end
endmodule

// ===== rtl/blexec_core.sv
// execution datapath for byte, literal and branch instructions
`timescale 1ns/1ps
// Overview of operation
// - decrement-skip subtracts one, stores per destination bit, flags kept
// - zero decrement result turns next instruction into no_operation
// - increment-skip adds one, stores per destination, zero skips next
// - increment_file adds one, stores per destination, updates zero flag
// - branch loads 11-bit literal into pc low, latch bits 4:3 on top
// - branch takes two instruction cycles and leaves flags untouched
// - or_literal_acc ORs literal into accumulator, updates zero flag
// - or_acc_file ORs accumulator with file, stores per destination, zero
// - nibble_swap exchanges file nibbles, stores per destination, no flags
// - xor_acc_file XORs accumulator with file, per destination, zero flag
// - xor_literal_acc XORs accumulator with literal into accumulator, zero
// - every instruction is a 14-bit word of opcode plus operand fields
// - one instruction cycle spans four clocks
module blexec_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction and operands
    input wire logic [13:0] instr,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] pc_high_latch,
    // file register access
    output logic [6:0] file_raddr,
    output blexec_pkg::blex_fwr_t file_wr,
    // architectural state
    output logic [7:0] acc,
    output logic zero_flag,
    output logic [12:0] pc,
    // cycle marks
    output logic cycle_end,
    output logic flushing
);
    typedef struct packed {
        logic [1:0] phase;
        blexec_pkg::blex_state_t state;
        logic [7:0] acc;
        logic zero;
        logic [12:0] pc;
        blexec_pkg::blex_fwr_t fwr;
    } blex_core_t;

    blex_core_t s_reg;
    blex_core_t s_next;
    blexec_pkg::blex_op_t op;
    logic [13:0] eff_instr;
    logic [1:0] pcl_bits;

    // one clock domain, so the checks below share this clocking and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == blexec_pkg::ZERO8);
    endfunction

    // a flushed slot executes as an all-zero word, which decodes to nothing
    assign eff_instr = (s_reg.state == blexec_pkg::BLEX_ST_FLUSH) ?
        blexec_pkg::NOP_WORD : instr;

    blexec_decode u_decode (
        .instr(eff_instr),
        .op(op)
    );

    assign file_raddr = instr[blexec_pkg::FADDR_W-1:0];
    assign pcl_bits = pc_high_latch[blexec_pkg::PCL_HI:blexec_pkg::PCL_LO];
    assign cycle_end = (s_reg.phase == blexec_pkg::PHASE_LAST);
    assign flushing = (s_reg.state == blexec_pkg::BLEX_ST_FLUSH);
    assign acc = s_reg.acc;
    assign zero_flag = s_reg.zero;
    assign pc = s_reg.pc;
    assign file_wr = s_reg.fwr;

    // ************************************************************
    // next-state: results commit on the last phase only
    // ************************************************************
    always_comb begin
        logic [7:0] res;
        logic [7:0] lit;
        logic dest;
        logic wr_res;
        logic upd_z;
        logic skip;
        res = blexec_pkg::ZERO8;
        lit = instr[blexec_pkg::LIT8_W-1:0];
        dest = instr[blexec_pkg::DEST_BIT];
        wr_res = 1'b0;
        upd_z = 1'b0;
        skip = 1'b0;
        s_next = s_reg;
        s_next.fwr.we = 1'b0;
        s_next.phase = s_reg.phase + 2'h1;
        if (s_reg.phase == blexec_pkg::PHASE_LAST) begin
            s_next.state = blexec_pkg::BLEX_ST_EXEC;
            s_next.pc = s_reg.pc + 13'h0001;
            case (op)
                blexec_pkg::BLEX_DEC_SKIP: begin
                    res = file_rdata - blexec_pkg::ONE8;
                    wr_res = 1'b1;
                    skip = is_zero(res);
                end
                blexec_pkg::BLEX_INC_SKIP: begin
                    res = file_rdata + blexec_pkg::ONE8;
                    wr_res = 1'b1;
                    skip = is_zero(res);
                end
                blexec_pkg::BLEX_INC_FILE: begin
                    res = file_rdata + blexec_pkg::ONE8;
                    wr_res = 1'b1;
                    upd_z = 1'b1;
                end
                blexec_pkg::BLEX_OR_FILE: begin
                    res = s_reg.acc | file_rdata;
                    wr_res = 1'b1;
                    upd_z = 1'b1;
                end
                blexec_pkg::BLEX_XOR_FILE: begin
                    res = s_reg.acc ^ file_rdata;
                    wr_res = 1'b1;
                    upd_z = 1'b1;
                end
                blexec_pkg::BLEX_SWAP: begin
                    res = {file_rdata[blexec_pkg::NIB_W-1:0],
                        file_rdata[blexec_pkg::DATA_W-1:blexec_pkg::NIB_W]};
                    wr_res = 1'b1;
                end
                blexec_pkg::BLEX_OR_LIT: begin
                    res = s_reg.acc | lit;
                    s_next.acc = res;
                    upd_z = 1'b1;
                end
                blexec_pkg::BLEX_XOR_LIT: begin
                    res = s_reg.acc ^ lit;
                    s_next.acc = res;
                    upd_z = 1'b1;
                end
                blexec_pkg::BLEX_BRANCH: begin
                    // second cycle is a flush slot, flags untouched
                    s_next.pc = {pcl_bits,
                        instr[blexec_pkg::LIT11_W-1:0]};
                    skip = 1'b1;
                end
                default: begin
                    res = blexec_pkg::ZERO8;
                end
            endcase
            // destination select for byte ops
            if (wr_res && !dest) begin
                s_next.acc = res;
            end
            if (wr_res && dest) begin
                s_next.fwr.we = 1'b1;
                s_next.fwr.addr = instr[blexec_pkg::FADDR_W-1:0];
                s_next.fwr.data = res;
            end
            if (upd_z) begin
                s_next.zero = is_zero(res);
            end
            if (skip) begin
                s_next.state = blexec_pkg::BLEX_ST_FLUSH;
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.pc <= blexec_pkg::PC_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_PHASE_WRAP: assert property (
        cycle_end |=> !cycle_end [*3] ##1 cycle_end)
        else $error("instruction cycle is not four clocks");
    AST_DEC_RESULT: assert property (
        cycle_end && op == blexec_pkg::BLEX_DEC_SKIP && !instr[7] |=>
        acc == $past(file_rdata) - blexec_pkg::ONE8)
        else $error("decrement result wrong in accumulator");
    AST_DEC_FLAGS: assert property (
        cycle_end && op == blexec_pkg::BLEX_DEC_SKIP |=> $stable(zero_flag))
        else $error("decrement-skip changed zero flag");
    AST_DEC_SKIP: assert property (
        cycle_end && op == blexec_pkg::BLEX_DEC_SKIP &&
        file_rdata == blexec_pkg::ONE8 |=> flushing [*4] ##1 !flushing)
        else $error("zero decrement did not flush next slot");
    AST_INC_SKIP: assert property (
        cycle_end && op == blexec_pkg::BLEX_INC_SKIP &&
        file_rdata != 8'hFF |=> !flushing)
        else $error("nonzero increment flushed next slot");
    AST_INC_ZERO: assert property (
        cycle_end && op == blexec_pkg::BLEX_INC_FILE |=>
        zero_flag == ($past(file_rdata) == 8'hFF))
        else $error("increment zero flag wrong");
    AST_BRANCH_PC: assert property (
        cycle_end && op == blexec_pkg::BLEX_BRANCH |=>
        pc == {$past(pc_high_latch[4:3]), $past(instr[10:0])})
        else $error("branch target wrong");
    AST_BRANCH_TWO: assert property (
        cycle_end && op == blexec_pkg::BLEX_BRANCH |=>
        flushing && $stable(zero_flag) && $stable(acc))
        else $error("branch not two cycles or touched state");
    AST_FILE_DEST: assert property (
        cycle_end && op == blexec_pkg::BLEX_OR_FILE && instr[7] |=>
        file_wr.we && file_wr.data == ($past(acc) | $past(file_rdata)) &&
        $stable(acc))
        else $error("or to file destination wrong");
    AST_SWAP: assert property (
        cycle_end && op == blexec_pkg::BLEX_SWAP && !instr[7] |=>
        acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("nibble swap wrong");
    AST_XOR_LIT: assert property (
        cycle_end && op == blexec_pkg::BLEX_XOR_LIT |=>
        acc == ($past(acc) ^ $past(instr[7:0])) &&
        zero_flag == (acc == blexec_pkg::ZERO8))
        else $error("xor literal wrong");
    AST_OR_LIT: assert property (
        cycle_end && op == blexec_pkg::BLEX_OR_LIT |=>
        acc == ($past(acc) | $past(instr[7:0])))
        else $error("or literal wrong");
    AST_XOR_FILE: assert property (
        cycle_end && op == blexec_pkg::BLEX_XOR_FILE && !instr[7] |=>
        acc == ($past(acc) ^ $past(file_rdata)))
        else $error("xor file wrong");

    COV_SKIP: cover property (cycle_end && flushing);
    COV_BRANCH: cover property (cycle_end && op == blexec_pkg::BLEX_BRANCH);
    COV_FILE_WR: cover property (file_wr.we);
    COV_ZERO: cover property (zero_flag);
endmodule

// ===== verification/blexec_tb_top.sv
// testbench for the byte, literal and branch execution block
`timescale 1ns/1ps
module blexec_tb_top;
    // ************************************************************
    // signals and design
    // ************************************************************
    typedef struct packed {
        logic [5:0] op;
        logic [7:0] lo;
        logic [7:0] fd;
        logic [7:0] res;
        logic z;
    } blex_row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [13:0] instr = 14'h0000;
    logic [7:0] file_rdata = 8'h00;
    logic [7:0] pc_high_latch = 8'h00;
    logic [6:0] file_raddr;
    blexec_pkg::blex_fwr_t file_wr;
    logic [7:0] acc;
    logic zero_flag;
    logic [12:0] pc;
    logic cycle_end;
    logic flushing;
    int err_count = 0;
    int check_count = 0;
    logic [12:0] pc_exp;
    logic [7:0] acc_exp;
    logic seen_flush;
    logic wr;
    blex_row_t r;
    blex_row_t rows [16];

    // free-running clock, 10 ns period
    always #5 clk = ~clk;

    blexec_core dut (
        .clk(clk),
        .rst(rst),
        .instr(instr),
        .file_rdata(file_rdata),
        .pc_high_latch(pc_high_latch),
        .file_raddr(file_raddr),
        .file_wr(file_wr),
        .acc(acc),
        .zero_flag(zero_flag),
        .pc(pc),
        .cycle_end(cycle_end),
        .flushing(flushing)
    );

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_b(string nm, logic e, logic g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_w(string nm, logic [12:0] e, logic [12:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bounded wait for the last phase; a hang ends the run
    task automatic wait_end(output int n);
        n = 0;
        @(negedge clk);
        while (cycle_end !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (n >= 8) begin
            err_count++;
            $display("[FAIL] cycle_end expected 1 seen %b", cycle_end);
            end_sim();
        end
    endtask

    // entered at phase 0; inputs held for the whole instruction cycle
    task automatic exec(logic [13:0] ins, logic [7:0] fd, logic [7:0] lat);
        int n;
        instr = ins;
        file_rdata = fd;
        pc_high_latch = lat;
        wait_end(n);
        chk_w("phases", 13'h0002, 13'(n));
        chk_w("file_raddr", 13'(ins[6:0]), 13'(file_raddr));
        seen_flush = flushing;
        @(negedge clk);
    endtask

    // align to phase 0 after reset; an unknown word only bumps pc
    task automatic sync();
        int n;
        instr = blexec_pkg::NOP_WORD;
        wait_end(n);
        @(negedge clk);
    endtask

    task automatic check_st(logic [7:0] ea, logic ez, logic ew,
                            logic [7:0] ed, logic [6:0] eadr, logic ef);
        chk_w("acc", {5'h00, ea}, {5'h00, acc});
        chk_b("zero_flag", ez, zero_flag);
        chk_b("file_wr.we", ew, file_wr.we);
        if (ew) begin
            chk_w("file_wr.data", 13'(ed), 13'(file_wr.data));
            chk_w("file_wr.addr", 13'(eadr), 13'(file_wr.addr));
        end
        chk_w("pc", pc_exp, pc);
        chk_b("flushing", ef, seen_flush);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        // result rows: literals never write, byte ops write when bit 7 set
        rows[0] = '{blexec_pkg::OP_OR_LIT, 8'h00, 8'h00, 8'h00, 1'b1};
        rows[1] = '{blexec_pkg::OP_OR_LIT, 8'h5A, 8'h00, 8'h5A, 1'b0};
        rows[2] = '{blexec_pkg::OP_XOR_LIT, 8'h5A, 8'h00, 8'h00, 1'b1};
        rows[3] = '{blexec_pkg::OP_XOR_LIT, 8'hC3, 8'h00, 8'hC3, 1'b0};
        rows[4] = '{blexec_pkg::OP_OR_FILE, 8'h21, 8'h0C, 8'hCF, 1'b0};
        rows[5] = '{blexec_pkg::OP_OR_FILE, 8'hA2, 8'h30, 8'hFF, 1'b0};
        rows[6] = '{blexec_pkg::OP_XOR_FILE, 8'hA3, 8'hCF, 8'h00, 1'b1};
        rows[7] = '{blexec_pkg::OP_XOR_FILE, 8'h24, 8'h0F, 8'hC0, 1'b0};
        rows[8] = '{blexec_pkg::OP_INC_FILE, 8'h25, 8'hFF, 8'h00, 1'b1};
        rows[9] = '{blexec_pkg::OP_INC_FILE, 8'hA6, 8'h7F, 8'h80, 1'b0};
        rows[10] = '{blexec_pkg::OP_SWAP, 8'h27, 8'hA5, 8'h5A, 1'b0};
        rows[11] = '{blexec_pkg::OP_XOR_LIT, 8'h5A, 8'h00, 8'h00, 1'b1};
        rows[12] = '{blexec_pkg::OP_SWAP, 8'hA8, 8'h3C, 8'hC3, 1'b1};
        rows[13] = '{blexec_pkg::OP_DEC_SKIP, 8'h29, 8'h05, 8'h04, 1'b1};
        rows[14] = '{blexec_pkg::OP_INC_SKIP, 8'hAA, 8'h10, 8'h11, 1'b1};
        rows[15] = '{blexec_pkg::OP_OR_LIT, 8'h80, 8'h00, 8'h84, 1'b0};
        repeat (20) @(negedge clk);
        seen_flush = flushing;
        pc_exp = 13'h0000;
        check_st(8'h00, 1'b0, 1'b0, 8'h00, 7'h00, 1'b0);
        rst = 1'b0;
        sync();
        pc_exp = 13'h0001;
        acc_exp = 8'h00;
        foreach (rows[i]) begin
            r = rows[i];
            wr = !r.op[5] && r.lo[7];
            exec({r.op, r.lo}, r.fd, 8'h00);
            pc_exp = pc_exp + 13'h0001;
            acc_exp = wr ? acc_exp : r.res;
            check_st(acc_exp, r.z, wr, r.res, r.lo[6:0], 1'b0);
        end
        // zero decrement written back, then the skipped slot is ignored
        exec({blexec_pkg::OP_DEC_SKIP, 8'hAC}, 8'h01, 8'h00);
        pc_exp = pc_exp + 13'h0001;
        check_st(8'h84, 1'b0, 1'b1, 8'h00, 7'h2C, 1'b0);
        exec({blexec_pkg::OP_XOR_LIT, 8'hFF}, 8'h00, 8'h00);
        pc_exp = pc_exp + 13'h0001;
        check_st(8'h84, 1'b0, 1'b0, 8'h00, 7'h00, 1'b1);
        // increment wraps to zero into acc; flag kept, write in slot dropped
        exec({blexec_pkg::OP_INC_SKIP, 8'h2D}, 8'hFF, 8'h00);
        pc_exp = pc_exp + 13'h0001;
        check_st(8'h00, 1'b0, 1'b0, 8'h00, 7'h00, 1'b0);
        exec({blexec_pkg::OP_OR_FILE, 8'hAE}, 8'h55, 8'h00);
        pc_exp = pc_exp + 13'h0001;
        check_st(8'h00, 1'b0, 1'b0, 8'h00, 7'h00, 1'b1);
        // set the flag so the branches can show they leave it alone
        exec({blexec_pkg::OP_OR_LIT, 8'h00}, 8'h00, 8'h00);
        pc_exp = pc_exp + 13'h0001;
        check_st(8'h00, 1'b1, 1'b0, 8'h00, 7'h00, 1'b0);
        exec({blexec_pkg::OP_BRANCH, 11'h5A5}, 8'h00, 8'h18);
        pc_exp = 13'h1DA5;
        check_st(8'h00, 1'b1, 1'b0, 8'h00, 7'h00, 1'b0);
        exec({blexec_pkg::OP_XOR_LIT, 8'hFF}, 8'h00, 8'h00);
        pc_exp = 13'h1DA6;
        check_st(8'h00, 1'b1, 1'b0, 8'h00, 7'h00, 1'b1);
        // latch bits outside 4:3 must not reach the top of pc
        exec({blexec_pkg::OP_BRANCH, 11'h7FF}, 8'h00, 8'hE7);
        pc_exp = 13'h07FF;
        check_st(8'h00, 1'b1, 1'b0, 8'h00, 7'h00, 1'b0);
        exec({blexec_pkg::OP_BRANCH, 11'h123}, 8'h00, 8'h18);
        pc_exp = 13'h0800;
        check_st(8'h00, 1'b1, 1'b0, 8'h00, 7'h00, 1'b1);
        // reset in mid-run clears state, then execution resumes
        exec({blexec_pkg::OP_OR_LIT, 8'h81}, 8'h00, 8'h00);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        seen_flush = flushing;
        pc_exp = 13'h0000;
        check_st(8'h00, 1'b0, 1'b0, 8'h00, 7'h00, 1'b0);
        rst = 1'b0;
        sync();
        exec({blexec_pkg::OP_OR_LIT, 8'h81}, 8'h00, 8'h00);
        pc_exp = 13'h0002;
        check_st(8'h81, 1'b0, 1'b0, 8'h00, 7'h00, 1'b0);
        end_sim();
    end
endmodule
